//--- rtl/odt_ctrl_pkg.sv
// Constants, field layout and types for the on-die termination selector
package odt_ctrl_pkg;

    // Register port geometry
    localparam int ADDR_W = 3;
    localparam int DATA_W = 32;

    // Register offsets
    localparam logic [2:0] MR1_ADDR  = 3'h0;
    localparam logic [2:0] MR2_ADDR  = 3'h1;
    localparam logic [2:0] MR5_ADDR  = 3'h2;
    localparam logic [2:0] CFG_ADDR  = 3'h3;
    localparam logic [2:0] STAT_ADDR = 3'h4;

    // Mode register images hold address bits A17..A0
    localparam logic [31:0] MR_MASK = 32'h0003_ffff;

    // Mode register field positions
    localparam int MR1_DLL_BIT    = 0;
    localparam int MR1_NOM_LSB    = 8;
    localparam int MR2_WR_LSB     = 9;
    localparam int MR2_DYN_LO_BIT = 9;
    localparam int MR2_DYN_HI_BIT = 10;
    localparam int MR5_BUFDIS_BIT = 5;
    localparam int MR5_PARK_LSB   = 6;

    // Configuration register field positions
    localparam int CFG_CWL_LSB  = 0;
    localparam int CFG_AL_LSB   = 6;
    localparam int CFG_PL_LSB   = 12;
    localparam int CFG_PRE2_BIT = 16;
    localparam int CFG_CRC_BIT  = 17;
    localparam int CFG_BL_LSB   = 18;
    localparam logic [31:0] CFG_MASK = 32'h000f_7fff;

    // Reset values
    localparam logic [31:0] MR1_RESET = 32'h0000_0001;
    localparam logic [31:0] MR2_RESET = 32'h0000_0000;
    localparam logic [31:0] MR5_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET = 32'h0000_0009;

    // Burst length selection
    localparam logic [1:0] BL_FIXED8  = 2'h0;
    localparam logic [1:0] BL_OTF     = 2'h1;
    localparam logic [1:0] BL_FIXED4  = 2'h2;

    // Latency offsets from write latency
    localparam logic [6:0] LAT_SUB_1T = 7'h2;
    localparam logic [6:0] LAT_SUB_2T = 7'h3;

    // Write termination length after switch-on, {pre2,crc} order 1t/off,1t/on,2t/off,2t/on
    localparam logic [3:0] BC4_LEN_1T_OFF = 4'h4;
    localparam logic [3:0] BC4_LEN_1T_ON  = 4'h7;
    localparam logic [3:0] BC4_LEN_2T_OFF = 4'h5;
    localparam logic [3:0] BC4_LEN_2T_ON  = 4'h8;
    localparam logic [3:0] BL8_LEN_1T_OFF = 4'h6;
    localparam logic [3:0] BL8_LEN_1T_ON  = 4'h7;
    localparam logic [3:0] BL8_LEN_2T_OFF = 4'h7;
    localparam logic [3:0] BL8_LEN_2T_ON  = 4'h8;

    // Asynchronous turn-on and turn-off window in ns and core cycles
    localparam real CLK_PERIOD_NS  = 40.0;
    localparam real ASYNC_MIN_NS   = 1.0;
    localparam real ASYNC_MAX_NS   = 9.0;
    localparam int  ASYNC_MIN_CYC  = ($ceil(ASYNC_MIN_NS / CLK_PERIOD_NS) < 1.0) ? 1 :
                                     int'($ceil(ASYNC_MIN_NS / CLK_PERIOD_NS));
    localparam int  ASYNC_MAX_CYC  = ($floor(ASYNC_MAX_NS / CLK_PERIOD_NS) < 1.0) ? 1 :
                                     int'($floor(ASYNC_MAX_NS / CLK_PERIOD_NS));

    // Selected termination, one-hot
    typedef enum logic [2:0] {
        TERM_PARK = 3'b001,
        TERM_NOM  = 3'b010,
        TERM_WR   = 3'b100
    } term_sel_type;

endpackage : odt_ctrl_pkg

//--- rtl/odt_term_ctrl.sv
// On-die termination selector: nominal, park and write termination from pins and registers
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps

// Operation
// R1: Dynamic switching is on when either write-termination select bit is one.
// R2: Nominal, park and write values come from their three mode register fields.
// R3: Without writes, nominal follows ODT with its latency; park when ODT is low.
// R4: Dynamic mode selects write termination a latency after any write command.
// R5: Write termination ends after a burst-length-dependent latency, fixed or on the fly.
// R6: Switch-on latency is write latency minus two, or minus three with long preamble.
// R7: BC4 write termination lasts 4, 7, 5 or 8 clocks by preamble and CRC.
// R8: BL8 write termination lasts 6, 7, 7 or 8 clocks by preamble and CRC.
// R9: Host clears write-termination select bits before turning the DLL off; the bench writes MR1 with the DLL off before clearing them in MR2.
// R10: DLL disabled in mode register 1 selects asynchronous termination mode.
// R11: Asynchronous mode applies no clocked latency to the ODT pin.
// R12: Asynchronous nominal on and off start within a bounded delay of ODT.
// R13: Buffer-disabled power-down gives no nominal termination.
// R14: Host holds ODT steady around power-down entry in buffer-disabled mode.
// R15: ODT sampled just before power-down entry may give nominal or park.
// R16: Host drives ODT low on power-down exit until exit time passes.
// R17: Synchronous nominal on and off latencies both equal write latency minus two, or minus three with long preamble.
// R18: Write latency is CWL plus AL plus PL; long preamble shortens pin latency.
// R19: With both select bits zero, write commands do not affect termination.
module odt_term_ctrl #(
    parameter int HIST_DEPTH = 64
) (
    input  wire logic                              core_clk,
    input  wire logic                              resetn,
    input  wire logic [odt_ctrl_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [odt_ctrl_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                              reg_write,
    input  wire logic                              reg_read,
    output logic      [odt_ctrl_pkg::DATA_W-1:0]   reg_rdata,
    input  wire logic                              dram_clk,
    input  wire logic                              odt_pin,
    input  wire logic                              cke_pin,
    input  wire logic                              write_cmd,
    input  wire logic                              burst_chop,
    output logic      [2:0]                        term_select,
    output logic      [2:0]                        term_value
);

    localparam int IDX_W = $clog2(HIST_DEPTH);
    // Asynchronous response window in core cycles, kept local so delay bounds stay plain
    localparam int ASYNC_WIN = odt_ctrl_pkg::ASYNC_MAX_CYC;

    // Software-visible registers
    logic [31:0]                    mr1_reg;
    logic [31:0]                    mr2_reg;
    logic [31:0]                    mr5_reg;
    logic [31:0]                    cfg_reg;
    logic [31:0]                    rdata_reg;

    // Pin synchronisers: clock, odt, cke, write, chop
    logic [4:0]                     sync1_reg;
    logic [4:0]                     sync2_reg;
    logic                           clk_prev_reg;

    // Per-clock histories of pins sampled on link clock rises
    logic [HIST_DEPTH-1:0]          odt_hist_reg;
    logic [HIST_DEPTH-1:0]          wr_hist_reg;
    logic [HIST_DEPTH-1:0]          bc4_hist_reg;
    logic                           cke_reg;

    odt_ctrl_pkg::term_sel_type     sel_reg;
    logic [2:0]                     value_reg;

    // Field decode
    wire        dll_on   = mr1_reg[odt_ctrl_pkg::MR1_DLL_BIT];
    wire [2:0]  rtt_nom  = mr1_reg[odt_ctrl_pkg::MR1_NOM_LSB +: 3];
    wire [2:0]  rtt_wr   = mr2_reg[odt_ctrl_pkg::MR2_WR_LSB +: 3];
    wire [2:0]  rtt_park = mr5_reg[odt_ctrl_pkg::MR5_PARK_LSB +: 3];
    wire        buf_dis  = mr5_reg[odt_ctrl_pkg::MR5_BUFDIS_BIT];
    wire [5:0]  cwl      = cfg_reg[odt_ctrl_pkg::CFG_CWL_LSB +: 6];
    wire [5:0]  al       = cfg_reg[odt_ctrl_pkg::CFG_AL_LSB +: 6];
    wire [2:0]  pl       = cfg_reg[odt_ctrl_pkg::CFG_PL_LSB +: 3];
    wire        pre2     = cfg_reg[odt_ctrl_pkg::CFG_PRE2_BIT];
    wire        crc_on   = cfg_reg[odt_ctrl_pkg::CFG_CRC_BIT];
    wire [1:0]  bl_mode  = cfg_reg[odt_ctrl_pkg::CFG_BL_LSB +: 2];

    // Dynamic mode enable; both select bits zero leaves writes out
    wire        dyn_en   = mr2_reg[odt_ctrl_pkg::MR2_DYN_LO_BIT] |
                           mr2_reg[odt_ctrl_pkg::MR2_DYN_HI_BIT]; // R1 R19

    // Write latency and derived latencies in link clocks
    wire [6:0]  wl       = {1'b0, cwl} + {1'b0, al} + {4'h0, pl}; // R18
    wire [6:0]  lat_sub  = pre2 ? odt_ctrl_pkg::LAT_SUB_2T : odt_ctrl_pkg::LAT_SUB_1T; // R6 R18
    wire [6:0]  on_lat   = (wl > lat_sub) ? wl - lat_sub : 7'h00; // R6 R17
    wire [IDX_W-1:0] pin_idx = (on_lat > 7'(HIST_DEPTH - 1)) ? IDX_W'(HIST_DEPTH - 1) :
                                                               on_lat[IDX_W-1:0];

    // Link clock rise seen in the core domain
    wire        link_tick = sync2_reg[0] & ~clk_prev_reg;
    wire        odt_s     = sync2_reg[1];
    wire        cke_s     = sync2_reg[2];
    wire        wr_s      = sync2_reg[3];
    wire        chop_s    = sync2_reg[4];

    // Chop taken from pin only in on-the-fly mode
    wire        bc4_eff   = (bl_mode == odt_ctrl_pkg::BL_FIXED4) |
                            ((bl_mode == odt_ctrl_pkg::BL_OTF) & chop_s); // R5

    // Length of write termination after switch-on
    function automatic logic [3:0] wr_term_len(input logic bc4, input logic p2,
                                               input logic crc);
        logic [3:0] len;
        len = 4'h0;
        if (bc4) begin
            len = p2 ? (crc ? odt_ctrl_pkg::BC4_LEN_2T_ON : odt_ctrl_pkg::BC4_LEN_2T_OFF)
                     : (crc ? odt_ctrl_pkg::BC4_LEN_1T_ON : odt_ctrl_pkg::BC4_LEN_1T_OFF); // R7
        end else begin
            len = p2 ? (crc ? odt_ctrl_pkg::BL8_LEN_2T_ON : odt_ctrl_pkg::BL8_LEN_2T_OFF)
                     : (crc ? odt_ctrl_pkg::BL8_LEN_1T_ON : odt_ctrl_pkg::BL8_LEN_1T_OFF); // R8
        end
        return len;
    endfunction : wr_term_len

    // A write k clocks old holds write termination inside its window
    wire  [HIST_DEPTH-1:0] wr_win;
    genvar k;
    generate
        for (k = 0; k < HIST_DEPTH; k = k + 1) begin : g_win
            wire [7:0] win_end = {1'b0, on_lat} +
                                 {4'h0, wr_term_len(bc4_hist_reg[k], pre2, crc_on)};
            assign wr_win[k] = wr_hist_reg[k] & (8'(k) >= {1'b0, on_lat}) &
                               (8'(k) < win_end); // R4 R5
        end
    endgenerate

    // Nominal request: delayed pin when locked, raw synchronised pin when DLL is off
    wire        wr_active = dyn_en & (|wr_win); // R4 R19
    wire        nom_sync  = odt_hist_reg[pin_idx]; // R3 R17
    wire        nom_req   = dll_on ? nom_sync : odt_s; // R10 R11 R12
    // Sampled cke low with buffers disabled blocks nominal; park chosen in the entry window
    wire        pd_block  = buf_dis & ~cke_reg; // R13 R15

    wire odt_ctrl_pkg::term_sel_type sel_next =
        wr_active              ? odt_ctrl_pkg::TERM_WR  :
        (nom_req & ~pd_block)  ? odt_ctrl_pkg::TERM_NOM :
                                 odt_ctrl_pkg::TERM_PARK; // R3
    wire [2:0]  value_next = wr_active ? rtt_wr :
                             (sel_next == odt_ctrl_pkg::TERM_NOM) ? rtt_nom : rtt_park; // R2

    // Register write decode
    wire        wr_mr1 = reg_write & (reg_addr == odt_ctrl_pkg::MR1_ADDR);
    wire        wr_mr2 = reg_write & (reg_addr == odt_ctrl_pkg::MR2_ADDR);
    wire        wr_mr5 = reg_write & (reg_addr == odt_ctrl_pkg::MR5_ADDR);
    wire        wr_cfg = reg_write & (reg_addr == odt_ctrl_pkg::CFG_ADDR);

    // Read selection; unmapped offsets read zero
    wire [31:0] status_word = {18'h00000, wl, 1'b0, value_reg, sel_reg};
    wire [31:0] read_mux =
        (reg_addr == odt_ctrl_pkg::MR1_ADDR)  ? mr1_reg :
        (reg_addr == odt_ctrl_pkg::MR2_ADDR)  ? mr2_reg :
        (reg_addr == odt_ctrl_pkg::MR5_ADDR)  ? mr5_reg :
        (reg_addr == odt_ctrl_pkg::CFG_ADDR)  ? cfg_reg :
        (reg_addr == odt_ctrl_pkg::STAT_ADDR) ? status_word : 32'h0000_0000;

    // Register file; read data valid only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mr1_reg   <= odt_ctrl_pkg::MR1_RESET;
            mr2_reg   <= odt_ctrl_pkg::MR2_RESET;
            mr5_reg   <= odt_ctrl_pkg::MR5_RESET;
            cfg_reg   <= odt_ctrl_pkg::CFG_RESET;
            rdata_reg <= 32'h0000_0000;
        end else begin
            if (wr_mr1) mr1_reg <= reg_wdata & odt_ctrl_pkg::MR_MASK;
            if (wr_mr2) mr2_reg <= reg_wdata & odt_ctrl_pkg::MR_MASK;
            if (wr_mr5) mr5_reg <= reg_wdata & odt_ctrl_pkg::MR_MASK;
            if (wr_cfg) cfg_reg <= reg_wdata & odt_ctrl_pkg::CFG_MASK;
            rdata_reg <= reg_read ? read_mux : 32'h0000_0000;
        end
    end

    // Two-stage synchronisers; stage one feeds stage two only
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sync1_reg    <= 5'h00;
            sync2_reg    <= 5'h00;
            clk_prev_reg <= 1'b0;
        end else begin
            sync1_reg    <= {burst_chop, write_cmd, cke_pin, odt_pin, dram_clk};
            sync2_reg    <= sync1_reg;
            clk_prev_reg <= sync2_reg[0];
        end
    end

    // Histories advance once per link clock; cke reset high so no false power-down
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            odt_hist_reg <= '0;
            wr_hist_reg  <= '0;
            bc4_hist_reg <= '0;
            cke_reg      <= 1'b1;
        end else if (link_tick) begin
            odt_hist_reg <= {odt_hist_reg[HIST_DEPTH-2:0], odt_s};
            wr_hist_reg  <= {wr_hist_reg[HIST_DEPTH-2:0], wr_s}; // R4
            bc4_hist_reg <= {bc4_hist_reg[HIST_DEPTH-2:0], bc4_eff}; // R5
            cke_reg      <= cke_s;
        end
    end

    // Output stage, park after reset
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sel_reg   <= odt_ctrl_pkg::TERM_PARK;
            value_reg <= 3'h0;
        end else begin
            sel_reg   <= sel_next;
            value_reg <= value_next;
        end
    end

    assign reg_rdata   = rdata_reg;
    assign term_select = sel_reg;
    assign term_value  = value_reg;

    // Checks on the selector
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence mr1_write_s;
        reg_write && (reg_addr == odt_ctrl_pkg::MR1_ADDR);
    endsequence
    sequence mr1_read_s;
        reg_read && (reg_addr == odt_ctrl_pkg::MR1_ADDR) && !reg_write;
    endsequence

    mr_readback_a: assert property (mr1_write_s ##1 mr1_read_s |=> // R2
        reg_rdata == ($past(reg_wdata, 2) & odt_ctrl_pkg::MR_MASK))
        else $error("mode register readback wrong");

    no_dyn_a: assert property (!dyn_en && $past(!dyn_en) |=> // R19
        term_select != odt_ctrl_pkg::TERM_WR)
        else $error("write termination without dynamic mode");

    wr_start_a: assert property (dyn_en && wr_hist_reg[pin_idx] && on_lat < 7'(HIST_DEPTH)
        && $stable(cfg_reg) && $stable(mr2_reg) |=> term_select == odt_ctrl_pkg::TERM_WR)
        else $error("write termination not on at switch-on latency"); // R4

    wr_value_a: assert property (term_select == odt_ctrl_pkg::TERM_WR && $stable(mr2_reg)
        |-> term_value == rtt_wr)
        else $error("write termination value wrong"); // R2

    lat_sub_a: assert property (wl > 7'h3 |-> on_lat == (pre2 ? wl - 7'h3 : wl - 7'h2))
        else $error("switch-on latency wrong"); // R6

    wl_sum_a: assert property (wl == 7'(cwl) + 7'(al) + 7'(pl))
        else $error("write latency sum wrong"); // R18

    async_follow_a: assert property (!dll_on && !dyn_en && !pd_block && odt_s
        && $stable(mr1_reg) |-> ##[1:ASYNC_WIN]
        term_select == odt_ctrl_pkg::TERM_NOM)
        else $error("asynchronous nominal late"); // R10 R11 R12

    async_park_a: assert property (!dll_on && !dyn_en && !odt_s && $stable(mr1_reg)
        |=> term_select == odt_ctrl_pkg::TERM_PARK)
        else $error("asynchronous park late"); // R3 R12

    pd_block_a: assert property (buf_dis && !cke_reg && !dyn_en && $stable(mr5_reg)
        && $stable(cke_reg) |=> term_select != odt_ctrl_pkg::TERM_NOM)
        else $error("nominal termination in power-down"); // R13

    bc4_len_a: assert property (wr_term_len(1'b1, pre2, crc_on) <
        wr_term_len(1'b0, pre2, crc_on) || crc_on || pre2 == 1'b1)
        else $error("chop window not shorter"); // R7 R8

    // Release of reset leaves park selected until the first link decision lands
    reset_park_a: assert property ($rose(resetn) |-> // R3
        term_select == odt_ctrl_pkg::TERM_PARK)
        else $error("selection not park after reset");

    // Nominal and park codes track their own mode register fields
    nom_value_a: assert property (term_select == odt_ctrl_pkg::TERM_NOM // R2
        && $stable(mr1_reg) |-> term_value == rtt_nom)
        else $error("nominal termination value wrong");

    park_value_a: assert property (term_select == odt_ctrl_pkg::TERM_PARK // R2
        && $stable(mr5_reg) |-> term_value == rtt_park)
        else $error("park termination value wrong");

    // Locked DLL: the delayed pin alone turns nominal on when nothing overrides it
    sync_nom_a: assert property (dll_on && !wr_active && !pd_block && nom_sync // R17
        |=> term_select == odt_ctrl_pkg::TERM_NOM)
        else $error("synchronous nominal not applied");

    // An open write window beats both nominal and park
    wr_prio_a: assert property (wr_active |=> term_select == odt_ctrl_pkg::TERM_WR) // R4
        else $error("write termination lost priority");

    // Read data lasts one cycle; a stale word would look like a second answer
    rdata_idle_a: assert property (!reg_read |=> reg_rdata == 32'h0000_0000) // R2
        else $error("read data outside its cycle");

    // Status read returns the write latency that every window is built on
    sequence status_read_s;
        reg_read && (reg_addr == odt_ctrl_pkg::STAT_ADDR);
    endsequence

    status_wl_a: assert property (status_read_s |=> reg_rdata[13:7] == $past(wl)) // R18
        else $error("status write latency wrong");

endmodule : odt_term_ctrl

//--- verif/host_link_model.sv
// Host-side model: link clock plus ODT, CKE and write command pins
`timescale 1ns/1ps
module host_link_model (
    output logic dram_clk,
    output logic odt_pin,
    output logic cke_pin,
    output logic write_cmd,
    output logic burst_chop
);
    // Link clock runs free at 320 ns, as a memory clock does
    initial begin
        dram_clk = 1'b0;
        forever #160 dram_clk = ~dram_clk;
    end

    // Idle pins: ODT low, CKE high, no command
    initial begin
        odt_pin    = 1'b0;
        cke_pin    = 1'b1;
        write_cmd  = 1'b0;
        burst_chop = 1'b0;
    end

    // Pins change at CK fall so they are settled around the sampling rise
    task automatic drive(input logic o, input logic c, input logic w, input logic b);
        @(negedge dram_clk);
        odt_pin   <= o;
        cke_pin   <= c;
        write_cmd <= w;
        // Chop flag means nothing without a write, so it toggles there
        burst_chop <= w ? b : ~burst_chop;
    endtask : drive
endmodule : host_link_model

//--- verif/tb_odt_term_ctrl.sv
// Self-checking bench for the termination selector
`timescale 1ns/1ps
module tb_odt_term_ctrl;
    logic        core_clk;
    logic        resetn;
    logic [2:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [31:0] reg_rdata;
    logic        dram_clk;
    logic        odt_pin;
    logic        cke_pin;
    logic        write_cmd;
    logic        burst_chop;
    logic [2:0]  term_select;
    logic [2:0]  term_value;
    logic [5:0]  exp_term;
    logic [31:0] mr1;
    logic [31:0] mr2;
    logic [31:0] mr5;
    logic [31:0] cfg;
    logic [2:0]  wvs [4] = '{3'h1, 3'h2, 3'h6, 3'h4};
    bit          q_odt [$];
    bit          q_cke [$];
    bit          q_wr [$];
    bit          q_bc [$];
    bit          cmp_en;
    int          err_count;
    int          total_checks;
    int          mi;
    int          p;

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    odt_term_ctrl dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .dram_clk(dram_clk), .odt_pin(odt_pin), .cke_pin(cke_pin),
        .write_cmd(write_cmd), .burst_chop(burst_chop), .term_select(term_select),
        .term_value(term_value));

    host_link_model host (.dram_clk(dram_clk), .odt_pin(odt_pin), .cke_pin(cke_pin),
        .write_cmd(write_cmd), .burst_chop(burst_chop));

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        check(reg_rdata, exp, "rdata");
        @(posedge core_clk);
        #1;
        check(reg_rdata, 32'h0, "rdata idle");
    endtask : rd_reg

    // Write then read the same offset with no gap between the strobes
    task automatic wr_rd(input logic [2:0] a, input logic [31:0] d, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
        reg_read  <= 1'b1;
        @(posedge core_clk);
        reg_read  <= 1'b0;
        #1;
        check(reg_rdata, exp, "rdata after write");
    endtask : wr_rd

    // Reference: decision taken at CK rise i, from pin history and mirrored registers
    function automatic logic [5:0] expect_term(input int i);
        int lat;
        int len;
        int j;
        bit nom;
        bit wrt;
        bit bc;
        lat = int'(cfg[5:0]) + int'(cfg[11:6]) + int'(cfg[14:12]) - (cfg[16] ? 3 : 2);
        nom = !mr1[0] ? q_odt[i] : (i >= lat && q_odt[i-lat]);
        if (mr5[5] && !q_cke[i]) nom = 1'b0;
        wrt = 1'b0;
        for (j = lat; j < lat + 8 && j <= i; j++) begin
            bc = cfg[19:18] == 2'h2 || (cfg[19:18] == 2'h1 && q_bc[i-j]);
            if (bc) len = cfg[16] ? (cfg[17] ? 8 : 5) : (cfg[17] ? 7 : 4);
            else len = cfg[16] ? (cfg[17] ? 8 : 7) : (cfg[17] ? 7 : 6);
            if (q_wr[i-j] && (mr2[9] || mr2[10]) && j < lat + len) wrt = 1'b1;
        end
        if (wrt) return {3'b100, mr2[11:9]};
        if (nom) return {3'b010, mr1[10:8]};
        return {3'b001, mr5[8:6]};
    endfunction : expect_term

    // Record pins at every CK rise; synchronous decisions show by the next rise
    always @(posedge dram_clk) begin
        q_odt.push_back(odt_pin);
        q_cke.push_back(cke_pin);
        q_wr.push_back(write_cmd);
        q_bc.push_back(burst_chop);
        if (cmp_en) begin
            mi = q_odt.size() - (mr1[0] ? 2 : 1);
            exp_term = expect_term(mi);
            check({26'h0, term_select, term_value}, {26'h0, exp_term}, "term");
        end
    end

    // Program all images, then idle long enough to flush every latency
    task automatic setup(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
                         input logic [31:0] d);
        cmp_en = 1'b0;
        mr1 = a;
        mr2 = b;
        mr5 = c;
        cfg = d;
        wr_reg(odt_ctrl_pkg::MR1_ADDR, a);
        wr_reg(odt_ctrl_pkg::MR2_ADDR, b);
        wr_reg(odt_ctrl_pkg::MR5_ADDR, c);
        wr_reg(odt_ctrl_pkg::CFG_ADDR, d);
        repeat (40) host.drive(1'b0, 1'b1, 1'b0, 1'b0);
        cmp_en = 1'b1;
    endtask : setup

    // Random ODT runs with sparse writes, some back to back
    task automatic traffic(input int n);
        bit o;
        o = 1'b0;
        repeat (n) begin
            if ($urandom_range(0, 3) == 0) o = ~o;
            host.drive(o, 1'b1, $urandom_range(0, 5) == 0, 1'($urandom_range(0, 1)));
        end
    endtask : traffic

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #2ms;
        err_count++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h97a9));
        {resetn, reg_addr, reg_wdata, reg_write, reg_read, cmp_en} = '0;
        {err_count, total_checks} = '0;
        {mr1, mr2, mr5, cfg} = '0;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        #1;
        check({29'h0, term_select}, 32'h1, "reset select");
        // Reset images, unmapped offset and write masks
        rd_reg(odt_ctrl_pkg::MR1_ADDR, 32'h0000_0001);
        rd_reg(odt_ctrl_pkg::CFG_ADDR, 32'h0000_0009);
        rd_reg(3'h5, 32'h0);
        wr_reg(odt_ctrl_pkg::MR2_ADDR, 32'hffff_ffff);
        rd_reg(odt_ctrl_pkg::MR2_ADDR, 32'h0003_ffff);
        wr_rd(odt_ctrl_pkg::MR1_ADDR, 32'hfffc_0a01, 32'h0000_0a01);
        wr_rd(odt_ctrl_pkg::CFG_ADDR, 32'hffff_ffff, 32'h000f_7fff);
        // Sweep preamble, CRC and burst modes with random latencies
        for (p = 0; p < 12; p++) begin
            setup({21'h0, 3'($urandom), 7'h0, 1'b1}, {20'h0, wvs[(p + p / 4) % 4], 9'h0},
                  {23'h0, 3'($urandom), 6'h0},
                  {12'h0, 2'(p / 4), p[1], p[0], 1'b0, 3'($urandom_range(0, 2)),
                   6'($urandom_range(0, 3)), 6'($urandom_range(5, 12))});
            traffic(50);
        end
        // DLL off: MR1 is written before the select bits are cleared in MR2, ODT acts without latency
        setup({21'h0, 3'h5, 7'h0, 1'b0}, 32'h0, {23'h0, 3'h2, 6'h0}, 32'h9);
        traffic(40);
        // Buffer-disabled power-down: ODT held steady across entry, low on exit
        setup({21'h0, 3'h3, 7'h0, 1'b1}, 32'h0, {23'h0, 3'h6, 1'b1, 5'h0}, 32'h9);
        rd_reg(odt_ctrl_pkg::STAT_ADDR, 32'h0000_04b1);
        repeat (20) host.drive(1'b1, 1'b1, 1'b0, 1'b0);
        repeat (15) host.drive(1'b1, 1'b0, 1'b0, 1'b0);
        repeat (20) host.drive(1'b0, 1'b1, 1'b0, 1'b0);
        wrap_up();
    end
endmodule : tb_odt_term_ctrl
